//--- pahp_pkg.sv
// Purpose: Shared constants and types for the converter host port
// Assumes: 250 MHz system clock
// Notes:   Conversion period timed in system clock cycles
package pahp_pkg;
  localparam int unsigned RES_W          = 10;
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned CONV_TIME_NS   = 6000;
  localparam int unsigned CONV_CYCLES    =
    (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W          = 16;
  localparam logic [9:0]  RESULT_MAX     = 10'h3FF;
  localparam logic [9:0]  RESULT_MIN     = 10'h000;
  localparam logic [9:0]  LATCH_RST      = 10'h000;

  typedef enum logic [1:0] {
    PAHP_IDLE = 2'b00,
    PAHP_CONV = 2'b01,
    PAHP_DONE = 2'b10
  } pahp_state_t;

  // Synchronised host strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } pahp_strb_t;
endpackage

//--- pahp_sync.sv
// Purpose: Two-stage synchroniser for one asynchronous level
// Assumes: Single system clock
// Notes:   Resets to the idle (high) level of the strobes
`timescale 1ns/1ns
module pahp_sync (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb begin
    meta_nxt = i_d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b1;
      o_q    <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      o_q    <= q_nxt;
    end
  end
endmodule

//--- pahp_top.sv
// Purpose: Control and parallel output port of a 10-bit SAR converter
// Assumes: Strobes asynchronous to i_clk_sys; sample code from an
//          external comparator model on i_sample_code
// Notes:   Data bus is two signals: value and enable
// Function
// (RULE1) Top data line carries MSB bit 10
// (RULE2) Done flag low only after latch loaded
// (RULE3) Host uses flag as interrupt or poll
// (RULE4) CS and RD low drive latch on bus
// (RULE5) Latch captures at done flag falling edge; here it loads one cycle before the flag falls
// (RULE6) RD falling edge returns flag high
// (RULE7) Input above top reference gives all ones
// (RULE8) Input below bottom reference gives zeros
// (RULE9) Between references result is proportional
// (RULE10) WR rising edge with CS starts conversion
// (RULE11) Hold analog input until conversion completes
// (RULE12) Sample mode outside the conversion period
// (RULE13) Strobes ignored unless chip select low
// (RULE14) Lowest data line carries LSB bit 1
// (RULE15) Bus high impedance when CS or RD high
// (RULE16) Conversion period timed by a counter
`timescale 1ns/1ns
module pahp_top #(
  parameter logic [15:0] CONV_CNT = 16'(pahp_pkg::CONV_CYCLES)
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [9:0] i_sample_code,
  input  wire logic       i_over_ref_hi,
  input  wire logic       i_under_ref_lo,
  output logic      [9:0] o_data,
  output logic      [9:0] o_data_oe,
  output logic            o_done_n,
  output logic            o_hold
);
  pahp_pkg::pahp_strb_t strb;
  pahp_pkg::pahp_strb_t strb_d_r;
  pahp_pkg::pahp_state_t state_r;
  pahp_pkg::pahp_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [9:0]  code_r;
  logic [9:0]  code_nxt;
  logic [9:0]  data_nxt;
  logic [9:0]  oe_nxt;
  logic        done_n_nxt;
  logic        hold_nxt;
  logic        wr_rise;
  logic        rd_fall;
  logic        rd_active;
  logic        cs_sync;
  logic        rd_sync;
  logic        wr_sync;

  pahp_sync u_sync_cs (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
                       .i_d(i_cs_n), .o_q(cs_sync));
  pahp_sync u_sync_rd (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
                       .i_d(i_rd_n), .o_q(rd_sync));
  pahp_sync u_sync_wr (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
                       .i_d(i_wr_n), .o_q(wr_sync));

  // Each synchroniser drives its own net; the carrier is built here
  always_comb begin
    strb.cs_n = cs_sync;
    strb.rd_n = rd_sync;
    strb.wr_n = wr_sync;
  end

  always_comb begin
    wr_rise   = !strb.cs_n && strb.wr_n && !strb_d_r.wr_n; // RULE10 RULE13
    rd_fall   = !strb.cs_n && !strb.rd_n && strb_d_r.rd_n; // RULE13
    rd_active = !strb.cs_n && !strb.rd_n;                  // RULE4 RULE13
  end

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    code_nxt   = code_r;
    done_n_nxt = o_done_n;
    hold_nxt   = 1'b0;                                     // RULE12
    // Clears first, so a completion in the same cycle still sets
    if (rd_fall)
      done_n_nxt = 1'b1;                                   // RULE6
    if (wr_rise && state_r == pahp_pkg::PAHP_IDLE)
      done_n_nxt = 1'b1;                                   // RULE10
    case (state_r)
      pahp_pkg::PAHP_IDLE: begin
        if (wr_rise) begin
          state_nxt = pahp_pkg::PAHP_CONV;
          cnt_nxt   = 16'h0001;
          hold_nxt  = 1'b1;                                // RULE11
        end
      end
      pahp_pkg::PAHP_CONV: begin
        hold_nxt = 1'b1;                                   // RULE11
        if (cnt_r >= CONV_CNT) begin                       // RULE16
          state_nxt = pahp_pkg::PAHP_DONE;
          hold_nxt  = 1'b0;
          if (i_over_ref_hi)
            code_nxt = pahp_pkg::RESULT_MAX;               // RULE7
          else if (i_under_ref_lo)
            code_nxt = pahp_pkg::RESULT_MIN;               // RULE8
          else
            code_nxt = i_sample_code;                      // RULE9
        end else begin
          cnt_nxt = cnt_r + 16'h0001;                      // RULE16
        end
      end
      pahp_pkg::PAHP_DONE: begin
        // Latch loaded last cycle; flag falls now
        done_n_nxt = 1'b0;                                 // RULE2 RULE5
        state_nxt  = pahp_pkg::PAHP_IDLE;
      end
      default: state_nxt = pahp_pkg::PAHP_IDLE;
    endcase
  end

  always_comb begin
    data_nxt = code_r;                                     // RULE1 RULE14
    oe_nxt   = rd_active ? 10'h3FF : 10'h000;              // RULE4 RULE15
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r  <= pahp_pkg::PAHP_IDLE;
      cnt_r    <= 16'h0000;
      code_r   <= pahp_pkg::LATCH_RST;
      strb_d_r <= 3'h7;
      o_data   <= 10'h000;
      o_data_oe <= 10'h000;
      o_done_n <= 1'b1;
      o_hold   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      code_r   <= code_nxt;
      strb_d_r <= strb;
      o_data   <= data_nxt;
      o_data_oe <= oe_nxt;
      o_done_n <= done_n_nxt;
      o_hold   <= hold_nxt;
    end
  end

  a_done_after_latch: assert property (@(posedge i_clk_sys) // RULE2
    disable iff (!i_rst_n) $fell(o_done_n) |-> $past(state_r) ==
      pahp_pkg::PAHP_DONE && $stable(code_r))
    else $error("done flag fell without a fresh result");
  a_latch_stable: assert property (@(posedge i_clk_sys) // RULE5
    disable iff (!i_rst_n) state_r != pahp_pkg::PAHP_CONV |=>
      $stable(code_r))
    else $error("latch changed outside completion");
  a_rd_clears_flag: assert property (@(posedge i_clk_sys) // RULE6
    disable iff (!i_rst_n) rd_fall && state_r != pahp_pkg::PAHP_DONE
      |=> o_done_n)
    else $error("read did not clear done flag");
  a_done_beats_read: assert property (@(posedge i_clk_sys) // RULE2
    disable iff (!i_rst_n) rd_fall && state_r == pahp_pkg::PAHP_DONE
      |=> !o_done_n)
    else $error("completion lost to a read edge");
  a_bus_drive: assert property (@(posedge i_clk_sys) // RULE4
    disable iff (!i_rst_n) rd_active |=> o_data_oe == 10'h3FF &&
      o_data == $past(code_r))
    else $error("bus not driven with latch");
  a_bus_float: assert property (@(posedge i_clk_sys) // RULE15
    disable iff (!i_rst_n) !rd_active |=> o_data_oe == 10'h000)
    else $error("bus driven while deselected");
  a_start_conv: assert property (@(posedge i_clk_sys) // RULE10
    disable iff (!i_rst_n) wr_rise && state_r == pahp_pkg::PAHP_IDLE
      |=> o_hold && state_r == pahp_pkg::PAHP_CONV)
    else $error("write edge did not start conversion");
  a_ignore_no_cs: assert property (@(posedge i_clk_sys) // RULE13
    disable iff (!i_rst_n) strb.cs_n && state_r ==
      pahp_pkg::PAHP_IDLE |=> state_r == pahp_pkg::PAHP_IDLE)
    else $error("strobe acted without chip select");
  a_sample_idle: assert property (@(posedge i_clk_sys) // RULE12
    disable iff (!i_rst_n) state_r == pahp_pkg::PAHP_IDLE &&
      !wr_rise |=> !o_hold)
    else $error("holding outside conversion");
  a_hold_span: assert property (@(posedge i_clk_sys) // RULE11
    disable iff (!i_rst_n) $rose(o_hold) |-> o_hold [*8])
    else $error("hold released early");
  a_full_scale: assert property (@(posedge i_clk_sys) // RULE7
    disable iff (!i_rst_n) state_r == pahp_pkg::PAHP_CONV &&
      state_nxt == pahp_pkg::PAHP_DONE && i_over_ref_hi
      |=> code_r == pahp_pkg::RESULT_MAX)
    else $error("over-range not all ones");
  a_zero_scale: assert property (@(posedge i_clk_sys) // RULE8
    disable iff (!i_rst_n) state_r == pahp_pkg::PAHP_CONV &&
      state_nxt == pahp_pkg::PAHP_DONE && !i_over_ref_hi &&
      i_under_ref_lo |=> code_r == pahp_pkg::RESULT_MIN)
    else $error("under-range not all zeros");
  c_conv_done: cover property (@(posedge i_clk_sys) $fell(o_done_n));
  c_read: cover property (@(posedge i_clk_sys) rd_fall && !o_done_n);
  c_restart: cover property (@(posedge i_clk_sys)
    wr_rise && !o_done_n);
  a_restart_clears: assert property (@(posedge i_clk_sys) // RULE10
    disable iff (!i_rst_n) wr_rise && state_r == pahp_pkg::PAHP_IDLE
      |=> o_done_n)
    else $error("new conversion left done flag low");
  a_flag_holds: assert property (@(posedge i_clk_sys) // RULE2
    disable iff (!i_rst_n) !o_done_n && !rd_fall &&
      !(wr_rise && state_r == pahp_pkg::PAHP_IDLE)
      |=> !o_done_n)
    else $error("done flag rose without read or start");
  a_mid_scale: assert property (@(posedge i_clk_sys) // RULE9
    disable iff (!i_rst_n) state_r == pahp_pkg::PAHP_CONV &&
      state_nxt == pahp_pkg::PAHP_DONE && !i_over_ref_hi &&
      !i_under_ref_lo |=> code_r == $past(i_sample_code))
    else $error("in-range code not latched");
  a_count_bound: assert property (@(posedge i_clk_sys) // RULE16
    disable iff (!i_rst_n) state_r == pahp_pkg::PAHP_CONV |->
      cnt_r >= 16'h0001 && cnt_r <= CONV_CNT)
    else $error("conversion counter out of range");
  c_over_range: cover property (@(posedge i_clk_sys)
    state_r == pahp_pkg::PAHP_CONV &&
      state_nxt == pahp_pkg::PAHP_DONE && i_over_ref_hi);
  c_under_range: cover property (@(posedge i_clk_sys)
    state_r == pahp_pkg::PAHP_CONV &&
      state_nxt == pahp_pkg::PAHP_DONE && i_under_ref_lo);
endmodule

//--- pahp_host.sv
// Purpose: Bus host model driving chip select and strobes
// Assumes: Strobes change only at falling clock edges
// Notes:   Released bus lines read back inverted, so stale data shows
`timescale 1ns/1ns
module pahp_host (
  input  wire logic       i_clk_sys,
  input  wire logic [9:0] i_data,
  input  wire logic [9:0] i_data_oe,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [9:0] o_bus
);
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
  end
  assign o_bus = (i_data_oe == 10'h3FF) ? i_data : ~i_data;
  task automatic start(input logic sel);
    @(negedge i_clk_sys);
    o_cs_n = ~sel;
    repeat (3) @(negedge i_clk_sys);
    o_wr_n = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    o_wr_n = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    o_cs_n = 1'b1;
  endtask
  task automatic rd_low(input logic sel);
    @(negedge i_clk_sys);
    o_cs_n = ~sel;
    repeat (3) @(negedge i_clk_sys);
    o_rd_n = 1'b0;
    repeat (5) @(negedge i_clk_sys);
  endtask
  task automatic rd_high();
    o_rd_n = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    o_cs_n = 1'b1;
    repeat (3) @(negedge i_clk_sys);
  endtask
endmodule

//--- pahp_top_bench.sv
// Purpose: Self-checking bench for the converter host port
// Assumes: Conversion count shortened to 8 cycles
// Notes:   Host model issues every strobe
`timescale 1ns/1ns
module pahp_top_bench;
  localparam logic [15:0] CONV_LEN = 16'h0008;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       over  = 1'b0;
  logic       under = 1'b0;
  logic [9:0] code  = 10'h000;
  logic       cs_n, rd_n, wr_n, done_n, hold;
  logic [9:0] data, oe, bus;
  int         mismatches = 0;
  int         checks     = 0;
  int         cycles     = 0;
  int         hold_cyc   = 0;
  always #2 clk = ~clk;
  pahp_top #(.CONV_CNT(CONV_LEN)) DUT (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_sample_code(code),
    .i_over_ref_hi(over), .i_under_ref_lo(under), .o_data(data),
    .o_data_oe(oe), .o_done_n(done_n), .o_hold(hold));
  pahp_host HOST (.i_clk_sys(clk), .i_data(data), .i_data_oe(oe),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_bus(bus));
  task automatic conclude();
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (hold === 1'b1)
      hold_cyc++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [9:0] exp,
                     input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Convert, optionally try strays with chip select high, then read
  task automatic conv_read(input logic [9:0] c, input logic hi,
                           input logic lo, input logic [9:0] exp,
                           input logic stray);
    int n;
    int h0;
    n = 0;
    h0 = hold_cyc;
    @(negedge clk);
    code  = c;
    over  = hi;
    under = lo;
    HOST.start(1'b1);
    chk("hold", 10'h001, {9'h000, hold});
    while (done_n !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("done", 10'h000, {9'h000, done_n});
    chk("hold", 10'h000, {9'h000, hold});
    chk("conv_len", CONV_LEN[9:0], 10'(hold_cyc - h0));
    code  = ~c;
    over  = 1'b0;
    under = 1'b0;
    if (stray) begin
      HOST.start(1'b0);
      chk("hold", 10'h000, {9'h000, hold});
      HOST.rd_low(1'b0);
      chk("oe", 10'h000, oe);
      chk("done", 10'h000, {9'h000, done_n});
      HOST.rd_high();
    end
    HOST.rd_low(1'b1);
    chk("bus", exp, bus);
    chk("oe", 10'h3FF, oe);
    chk("done", 10'h001, {9'h000, done_n});
    HOST.rd_high();
    chk("oe", 10'h000, oe);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk("done", 10'h001, {9'h000, done_n});
    chk("oe", 10'h000, oe);
    chk("hold", 10'h000, {9'h000, hold});
    conv_read(10'h155, 1'b1, 1'b0, 10'h3FF, 1'b0);
    conv_read(10'h2AA, 1'b0, 1'b1, 10'h000, 1'b1);
    conv_read(10'h201, 1'b0, 1'b0, 10'h201, 1'b0);
    conv_read(10'h0FE, 1'b0, 1'b0, 10'h0FE, 1'b1);
    conclude();
  end
endmodule
